// >>> logic/mft_pkg.sv
package mft_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTL    = 8'h00;
  localparam logic [7:0] ADDR_OA_CTL = 8'h04;
  localparam logic [7:0] ADDR_OB_CTL = 8'h08;
  localparam logic [7:0] ADDR_VEC    = 8'h0c;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_FLAGS  = 8'h14;
  localparam logic [7:0] ADDR_COUNT  = 8'h18;
  localparam logic [7:0] ADDR_REG0   = 8'h1c;
  localparam logic [7:0] ADDR_REG1   = 8'h20;
  localparam logic [7:0] ADDR_CMP0   = 8'h24;
  localparam logic [7:0] ADDR_CMP1   = 8'h28;
  localparam logic [7:0] ADDR_PRESC  = 8'h2c;
  localparam logic [2:0] SIZE_WORD   = 3'h2;
  // timer_control_reg fields
  localparam int CTL_MODE_LSB   = 0;
  localparam int CTL_EDGE_A_LSB = 4;
  localparam int CTL_EDGE_B_LSB = 6;
  localparam int CTL_SOFT_DIR   = 8;
  localparam int CTL_BIVALUE    = 9;
  localparam int CTL_CAPSEL     = 10;
  localparam int CTL_RUN        = 11;
  // output_a_control / output_b_control fields
  localparam int OUT_CM0_LSB    = 0;
  localparam int OUT_CM1_LSB    = 2;
  localparam int OUT_OUF_LSB    = 4;
  localparam int OUT_PRESET     = 6;
  localparam int OUT_EVT_EN     = 7;
  // pending, overrun and mask bit positions
  localparam int FLG_CM0     = 0;
  localparam int FLG_CM1     = 1;
  localparam int FLG_CP0     = 2;
  localparam int FLG_CP1     = 3;
  localparam int FLG_OUF     = 4;
  localparam int FLG_OVR_CM0 = 5;
  localparam int FLG_OVR_CP0 = 6;
  localparam int MASK_GLOBAL = 7;
  localparam int VEC_LSB     = 3;
  localparam logic [2:0] GRP_CMP = 3'h6;
  localparam logic [2:0] GRP_CAP = 3'h4;
  localparam logic [2:0] GRP_OUF = 3'h0;
  // output actions
  localparam logic [1:0] ACT_NOP    = 2'h0;
  localparam logic [1:0] ACT_SET    = 2'h1;
  localparam logic [1:0] ACT_RESET  = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // input pin function codes
  localparam logic [3:0] MODE_NONE      = 4'h0;
  localparam logic [3:0] MODE_B_TRIG    = 4'h1;
  localparam logic [3:0] MODE_A_GATE    = 4'h2;
  localparam logic [3:0] MODE_GATE_TRIG = 4'h3;
  localparam logic [3:0] MODE_B_CLK     = 4'h4;
  localparam logic [3:0] MODE_A_TRIG    = 4'h5;
  localparam logic [3:0] MODE_GATE_CLK  = 4'h6;
  localparam logic [3:0] MODE_TRIG_TRIG = 4'h7;
  localparam logic [3:0] MODE_CLK_UPDN  = 4'h8;
  localparam logic [3:0] MODE_UD_CLK    = 4'h9;
  localparam logic [3:0] MODE_TRIG_DIR  = 4'ha;
  localparam logic [3:0] MODE_UD_ONLY   = 4'hb;
  localparam logic [3:0] MODE_AUTODISC  = 4'hc;
  localparam logic [3:0] MODE_TRIG_CLK  = 4'hd;
  localparam logic [3:0] MODE_CLK_TRIG  = 4'he;
  localparam logic [3:0] MODE_TRIG_GATE = 4'hf;
  // reset values
  localparam logic [11:0] CTL_RST   = 12'h000;
  localparam logic [7:0]  OUT_RST   = 8'h00;
  localparam logic [7:0]  VEC_RST   = 8'h00;
  localparam logic [7:0]  MASK_RST  = 8'h00;
  localparam logic [7:0]  PRESC_RST = 8'h00;

  typedef struct packed {
    logic a_trig;
    logic b_trig;
    logic a_gate;
    logic b_gate;
    logic a_clk;
    logic b_clk;
    logic a_level;
    logic clk_updn;
    logic trig_dir;
    logic autod;
  } mft_roles_t;
endpackage : mft_pkg

// >>> logic/mft_pins_irq.sv
`timescale 1ns/100ps
// How it works
// - mode 0111: edge on a acts on reg zero, edge on b on reg one
// - mode 1000: a edge counts up, b edge counts down, b wins
// - mode 1001: level of a sets direction, b clocks the prescaler
// - mode 1010: a edge latches up, b edge latches down, b wins
// - mode 1011: level of a sets direction, internal clock counts
// - autodiscrimination: b rising while a low counts up, else nothing
// - autodiscrimination: b falling while a low counts down, else nothing
// - mode 1101: a triggers reg zero, b clocks the prescaler
// - mode 1110: a clocks the prescaler, b captures into reg one
// - mode 1111: a triggers reg zero, counting runs only while b low
// - each output driven by compare zero, compare one, over/underflow
// - each source applies nop, set, reset or toggle per output
// - chip event pulse from over/underflow or compare zero, each enabled
// - five sources in three groups with low vector bits 110, 100, 000
// - group 000 highest: over/underflow above capture above compare
// - upper five vector bits come from the vector register
// - each source masked by own bit, bit 7 gates all
// - new compare zero or capture zero while pending sets its overrun
// - a trigger reloads counter from reg zero, or captures into it
// - bivalue mode ignores b as a trigger
module mft_pins_irq
  import mft_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        timer_input_a,
  input  wire logic        timer_input_b,
  output logic             timer_output_a,
  output logic             timer_output_b,
  output logic             chip_event,
  output logic             irq_req,
  output logic [7:0]       irq_vector
);

  typedef struct packed {
    logic [11:0] ctl;
    logic [7:0]  oa_ctl;
    logic [7:0]  ob_ctl;
    logic [7:0]  vec;
    logic [7:0]  mask;
    logic [6:0]  flags;
    logic [15:0] count;
    logic [15:0] reg0;
    logic [15:0] reg1;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [7:0]  presc;
    logic [7:0]  presc_cnt;
    logic        dir_latch;
    logic        ina_q;
    logic        inb_q;
    logic        out_a;
    logic        out_b;
    logic        chip_evt;
    logic        irq;
    logic [7:0]  irq_vec;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    logic        rdy;
    logic        resp;
  } mft_state_t;

  localparam mft_state_t ST_RST = '{ctl: CTL_RST, oa_ctl: OUT_RST, ob_ctl: OUT_RST, vec: VEC_RST,
                                    mask: MASK_RST, presc: PRESC_RST, rdy: 1'b1, default: '0};

  mft_state_t st_ff;
  mft_state_t nxt_st;
  mft_roles_t roles;
  logic       edge_a;
  logic       edge_b;
  logic       rise_b;
  logic       fall_b;
  logic       gate_open;
  logic       presc_src;
  logic       presc_tick;
  logic       dir_up;
  logic       step_up;
  logic       step_dn;
  logic [15:0] new_count;
  logic       ouf_ev;
  logic       cm0_ev;
  logic       cm1_ev;
  logic       trig_a;
  logic       trig_b;
  logic       cp0_ev;
  logic       cp1_ev;
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  logic [4:0] act_src;
  logic       bus_wr;
  logic       acc;
  logic [31:0] rd;

  function automatic mft_roles_t mft_decode(input logic [3:0] m);
    mft_roles_t r;
    r = '0;
    unique case (m)
      MODE_NONE: ;
      MODE_B_TRIG: r.b_trig = 1'b1;
      MODE_A_GATE: r.a_gate = 1'b1;
      MODE_GATE_TRIG: begin
        r.a_gate = 1'b1;
        r.b_trig = 1'b1;
      end
      MODE_B_CLK: r.b_clk = 1'b1;
      MODE_A_TRIG: r.a_trig = 1'b1;
      MODE_GATE_CLK: begin
        r.a_gate = 1'b1;
        r.b_clk  = 1'b1;
      end
      MODE_TRIG_TRIG: begin
        r.a_trig = 1'b1;
        r.b_trig = 1'b1;
      end
      MODE_CLK_UPDN: r.clk_updn = 1'b1;
      MODE_UD_CLK: begin
        r.a_level = 1'b1;
        r.b_clk   = 1'b1;
      end
      MODE_TRIG_DIR: r.trig_dir = 1'b1;
      MODE_UD_ONLY: r.a_level = 1'b1;
      MODE_AUTODISC: r.autod = 1'b1;
      MODE_TRIG_CLK: begin
        r.a_trig = 1'b1;
        r.b_clk  = 1'b1;
      end
      MODE_CLK_TRIG: begin
        r.a_clk  = 1'b1;
        r.b_trig = 1'b1;
      end
      MODE_TRIG_GATE: begin
        r.a_trig = 1'b1;
        r.b_gate = 1'b1;
      end
    endcase
    return r;
  endfunction : mft_decode

  function automatic logic mft_act(input logic lvl, input logic [1:0] act, input logic fire);
    logic v;
    v = lvl;
    if (fire) begin
      unique case (act)
        ACT_NOP:    v = lvl;
        ACT_SET:    v = 1'b1;
        ACT_RESET:  v = 1'b0;
        ACT_TOGGLE: v = ~lvl;
      endcase
    end
    return v;
  endfunction : mft_act
  always_comb begin
    nxt_st = st_ff;
    roles  = mft_decode(st_ff.ctl[CTL_MODE_LSB +: 4]);
    nxt_st.ina_q = timer_input_a;
    nxt_st.inb_q = timer_input_b;
    edge_a = (st_ff.ctl[CTL_EDGE_A_LSB] & timer_input_a & ~st_ff.ina_q)
           | (st_ff.ctl[CTL_EDGE_A_LSB + 1] & ~timer_input_a & st_ff.ina_q);
    edge_b = (st_ff.ctl[CTL_EDGE_B_LSB] & timer_input_b & ~st_ff.inb_q)
           | (st_ff.ctl[CTL_EDGE_B_LSB + 1] & ~timer_input_b & st_ff.inb_q);
    rise_b = timer_input_b & ~st_ff.inb_q;
    fall_b = ~timer_input_b & st_ff.inb_q;
    // gates stop the prescaler input while the gate pin is high
    gate_open = ~(roles.a_gate & timer_input_a) & ~(roles.b_gate & timer_input_b);
    presc_src = roles.a_clk ? edge_a : (roles.b_clk ? edge_b : 1'b1);
    presc_src  = presc_src & gate_open & st_ff.ctl[CTL_RUN];
    presc_tick = presc_src & (st_ff.presc_cnt == st_ff.presc);
    if (presc_src) begin
      nxt_st.presc_cnt = presc_tick ? 8'h00 : st_ff.presc_cnt + 8'h01;
    end
    // down trigger wins when both edges land together
    if (roles.trig_dir && edge_b) begin
      nxt_st.dir_latch = 1'b0;
    end else if (roles.trig_dir && edge_a) begin
      nxt_st.dir_latch = 1'b1;
    end
    dir_up = roles.a_level ? timer_input_a
           : (roles.trig_dir ? st_ff.dir_latch : st_ff.ctl[CTL_SOFT_DIR]);
    if (roles.clk_updn) begin
      step_dn = st_ff.ctl[CTL_RUN] & edge_b;
      step_up = st_ff.ctl[CTL_RUN] & edge_a & ~edge_b;
    end else if (roles.autod) begin
      step_up = st_ff.ctl[CTL_RUN] & rise_b & ~timer_input_a;
      step_dn = st_ff.ctl[CTL_RUN] & fall_b & ~timer_input_a;
    end else begin
      step_up = presc_tick & dir_up;
      step_dn = presc_tick & ~dir_up;
    end
    new_count = step_up ? st_ff.count + 16'h0001 : st_ff.count - 16'h0001;
    ouf_ev = (step_up & (st_ff.count == 16'hffff)) | (step_dn & (st_ff.count == 16'h0000));
    cm0_ev = (step_up | step_dn) & (new_count == st_ff.cmp0);
    cm1_ev = (step_up | step_dn) & (new_count == st_ff.cmp1);
    if (step_up || step_dn) begin
      nxt_st.count = new_count;
    end
    if (ouf_ev && !st_ff.ctl[CTL_CAPSEL]) begin
      nxt_st.count = st_ff.reg0;
    end
    trig_a = roles.a_trig & edge_a;
    trig_b = roles.b_trig & edge_b & ~st_ff.ctl[CTL_BIVALUE];
    cp0_ev = trig_a & st_ff.ctl[CTL_CAPSEL];
    cp1_ev = trig_b;
    if (trig_a && !st_ff.ctl[CTL_CAPSEL]) begin
      nxt_st.count = st_ff.reg0;
    end
    if (cp0_ev) begin
      nxt_st.reg0 = st_ff.count;
    end
    if (cp1_ev) begin
      nxt_st.reg1 = st_ff.count;
    end
    // actions apply in order compare zero, compare one, over/underflow
    nxt_st.out_a = mft_act(mft_act(mft_act(st_ff.out_a, st_ff.oa_ctl[OUT_CM0_LSB +: 2], cm0_ev),
                                   st_ff.oa_ctl[OUT_CM1_LSB +: 2], cm1_ev),
                           st_ff.oa_ctl[OUT_OUF_LSB +: 2], ouf_ev);
    nxt_st.out_b = mft_act(mft_act(mft_act(st_ff.out_b, st_ff.ob_ctl[OUT_CM0_LSB +: 2], cm0_ev),
                                   st_ff.ob_ctl[OUT_CM1_LSB +: 2], cm1_ev),
                           st_ff.ob_ctl[OUT_OUF_LSB +: 2], ouf_ev);
    nxt_st.chip_evt = (ouf_ev & st_ff.oa_ctl[OUT_EVT_EN]) | (cm0_ev & st_ff.ob_ctl[OUT_EVT_EN]);
    flag_set = '0;
    flag_set[FLG_CM0]     = cm0_ev;
    flag_set[FLG_CM1]     = cm1_ev;
    flag_set[FLG_CP0]     = cp0_ev;
    flag_set[FLG_CP1]     = cp1_ev;
    flag_set[FLG_OUF]     = ouf_ev;
    flag_set[FLG_OVR_CM0] = cm0_ev & st_ff.flags[FLG_CM0];
    flag_set[FLG_OVR_CP0] = cp0_ev & st_ff.flags[FLG_CP0];
    // bus data phase; software writes beat same-cycle hardware updates, except flag sets
    bus_wr   = st_ff.dp_wr;
    flag_clr = '0;
    if (bus_wr) begin
      unique case (st_ff.dp_addr)
        ADDR_CTL:    nxt_st.ctl = hwdata[11:0];
        ADDR_OA_CTL: begin
          nxt_st.oa_ctl = hwdata[7:0];
          nxt_st.out_a  = hwdata[OUT_PRESET];
        end
        ADDR_OB_CTL: begin
          nxt_st.ob_ctl = hwdata[7:0];
          nxt_st.out_b  = hwdata[OUT_PRESET];
        end
        ADDR_VEC:    nxt_st.vec = hwdata[7:0];
        ADDR_MASK:   nxt_st.mask = hwdata[7:0];
        ADDR_FLAGS:  flag_clr = hwdata[6:0];
        ADDR_COUNT:  nxt_st.count = hwdata[15:0];
        ADDR_REG0:   nxt_st.reg0 = hwdata[15:0];
        ADDR_REG1:   nxt_st.reg1 = hwdata[15:0];
        ADDR_CMP0:   nxt_st.cmp0 = hwdata[15:0];
        ADDR_CMP1:   nxt_st.cmp1 = hwdata[15:0];
        ADDR_PRESC:  nxt_st.presc = hwdata[7:0];
        default: ;
      endcase
    end
    // a flag set in the clearing cycle survives
    nxt_st.flags = (st_ff.flags & ~flag_clr) | flag_set;
    act_src = st_ff.flags[4:0] & st_ff.mask[4:0] & {5{st_ff.mask[MASK_GLOBAL]}};
    nxt_st.irq = |act_src;
    nxt_st.irq_vec[7:VEC_LSB] = st_ff.vec[7:VEC_LSB];
    nxt_st.irq_vec[2:0] = act_src[FLG_OUF] ? GRP_OUF
                        : ((act_src[FLG_CP0] || act_src[FLG_CP1]) ? GRP_CAP : GRP_CMP);
    // read data sampled from the next state so a preceding write is seen
    acc = hsel & hready & htrans[1] & (hsize == SIZE_WORD);
    unique case (haddr[7:0])
      ADDR_CTL:    rd = {20'h0, nxt_st.ctl};
      ADDR_OA_CTL: rd = {24'h0, nxt_st.oa_ctl};
      ADDR_OB_CTL: rd = {24'h0, nxt_st.ob_ctl};
      ADDR_VEC:    rd = {24'h0, nxt_st.vec};
      ADDR_MASK:   rd = {24'h0, nxt_st.mask};
      ADDR_FLAGS:  rd = {25'h0, nxt_st.flags};
      ADDR_COUNT:  rd = {16'h0, nxt_st.count};
      ADDR_REG0:   rd = {16'h0, nxt_st.reg0};
      ADDR_REG1:   rd = {16'h0, nxt_st.reg1};
      ADDR_CMP0:   rd = {16'h0, nxt_st.cmp0};
      ADDR_CMP1:   rd = {16'h0, nxt_st.cmp1};
      ADDR_PRESC:  rd = {24'h0, nxt_st.presc};
      default:     rd = 32'h0;
    endcase
    nxt_st.dp_wr   = acc & hwrite;
    nxt_st.dp_addr = haddr[7:0];
    if (acc && !hwrite) begin
      nxt_st.rdata = rd;
    end
    nxt_st.rdy  = 1'b1;
    nxt_st.resp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout      = st_ff.rdy;
  assign hresp          = st_ff.resp;
  assign hrdata         = st_ff.rdata;
  assign timer_output_a = st_ff.out_a;
  assign timer_output_b = st_ff.out_b;
  assign chip_event     = st_ff.chip_evt;
  assign irq_req        = st_ff.irq;
  assign irq_vector     = st_ff.irq_vec;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic quiet;
  assign quiet = !st_ff.dp_wr;
  sequence ouf_armed_s;
    st_ff.flags[FLG_OUF] && st_ff.mask[FLG_OUF] && st_ff.mask[MASK_GLOBAL];
  endsequence
  sequence ouf_vector_s;
    irq_req && irq_vector[2:0] == GRP_OUF && irq_vector[7:3] == $past(st_ff.vec[7:3]);
  endsequence

  updn_clock_a: assert property (st_ff.ctl[3:0] == MODE_CLK_UPDN && st_ff.ctl[CTL_RUN] && edge_b
      && quiet && st_ff.count != 16'h0000 |=> st_ff.count == $past(st_ff.count) - 16'h0001)
    else $error("clock down edge did not decrement");
  autod_up_a: assert property (roles.autod && st_ff.ctl[CTL_RUN] && rise_b && !timer_input_a
      && quiet && st_ff.count != 16'hffff |=> st_ff.count == $past(st_ff.count) + 16'h0001)
    else $error("autodiscrimination rising edge did not increment");
  autod_hold_a: assert property (roles.autod && timer_input_a && quiet |=> $stable(st_ff.count))
    else $error("autodiscrimination changed count while a high");
  trig_down_a: assert property (roles.trig_dir && edge_b |=> !st_ff.dir_latch ##1 1)
    else $error("down trigger did not select down counting");
  trig_load_a: assert property (trig_a && !st_ff.ctl[CTL_CAPSEL] && quiet
      |=> st_ff.count == $past(st_ff.reg0))
    else $error("trigger did not reload from reg zero");
  trig_b_cap_a: assert property (trig_b && quiet |=> st_ff.reg1 == $past(st_ff.count))
    else $error("b trigger did not capture into reg one");
  bivalue_b_a: assert property (st_ff.ctl[CTL_BIVALUE] && quiet |=> $stable(st_ff.reg1))
    else $error("reg one changed in bivalue mode");
  gate_hold_a: assert property (st_ff.ctl[3:0] == MODE_TRIG_GATE && timer_input_b && !edge_a
      && quiet |=> $stable(st_ff.count) && $stable(st_ff.presc_cnt))
    else $error("counting while gate high");
  overrun_a: assert property (cm0_ev && st_ff.flags[FLG_CM0] |=> st_ff.flags[FLG_OVR_CM0])
    else $error("compare zero overrun not flagged");
  ouf_vector_a: assert property (ouf_armed_s |=> ouf_vector_s)
    else $error("over/underflow group not on top");
  global_mask_a: assert property (!st_ff.mask[MASK_GLOBAL] |=> !irq_req)
    else $error("interrupt raised with global mask clear");
  chip_evt_a: assert property (ouf_ev && st_ff.oa_ctl[OUT_EVT_EN] |=> chip_event ##1 1)
    else $error("chip event missing after over/underflow");
  preset_a: assert property (st_ff.dp_wr && st_ff.dp_addr == ADDR_OA_CTL
      |=> timer_output_a == $past(hwdata[OUT_PRESET]))
    else $error("output a preset not applied");
  toggle_a: assert property (ouf_ev && st_ff.oa_ctl[5:4] == ACT_TOGGLE && !cm0_ev && !cm1_ev
      && quiet |=> timer_output_a != $past(timer_output_a))
    else $error("toggle action did not toggle output a");

endmodule : mft_pins_irq

// >>> dv/mft_far_side.sv
`timescale 1ns/100ps
// far side: pin sources and the interrupt controller's vector fetch
module mft_far_side (
  input  wire logic       hclk,
  input  wire logic       want_a,
  input  wire logic       want_b,
  input  wire logic       irq_req,
  input  wire logic [7:0] irq_vector,
  output logic            timer_input_a,
  output logic            timer_input_b,
  output logic [7:0]      taken_vec_ff
);
  // pins move only on a clock edge, one cycle after the request
  always_ff @(posedge hclk) begin
    timer_input_a <= want_a;
    timer_input_b <= want_b;
    if (irq_req === 1'b1) begin
      taken_vec_ff <= irq_vector;
    end
  end
endmodule : mft_far_side

// >>> dv/mft_pins_irq_tb.sv
`timescale 1ns/100ps
module mft_pins_irq_tb;
  import mft_pkg::*;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        want_a  = 1'b0;
  logic        want_b  = 1'b0;
  logic        hreadyout, hresp, pin_a, pin_b, out_a, out_b, chip_event, irq_req;
  logic [31:0] hrdata;
  logic [7:0]  irq_vector, taken_vec;
  int          num_errors  = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          ev_cnt      = 0;
  int          e0;

  always #20 hclk = ~hclk;

  mft_pins_irq dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(SIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .timer_input_a(pin_a), .timer_input_b(pin_b),
    .timer_output_a(out_a), .timer_output_b(out_b), .chip_event(chip_event), .irq_req(irq_req),
    .irq_vector(irq_vector));

  mft_far_side far_u (.hclk(hclk), .want_a(want_a), .want_b(want_b), .irq_req(irq_req),
    .irq_vector(irq_vector), .timer_input_a(pin_a), .timer_input_b(pin_b), .taken_vec_ff(taken_vec));

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (chip_event === 1'b1) ev_cnt <= ev_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one single word transfer; master waits on hready, never on a cycle count
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask : rchk

  // enough cycles for pin, count, output and irq pipelines to settle
  task automatic pin(input logic a, input logic b);
    @(posedge hclk);
    want_a <= a;
    want_b <= b;
    repeat (6) @(posedge hclk);
  endtask : pin

  task automatic sc_reset();
    rchk(ADDR_CTL, 32'h0);
    rchk(ADDR_MASK, 32'h0);
    wr(8'h30, 32'h5a);
    rchk(8'h30, 32'h0);
    chk({out_a, out_b, irq_req, hresp}, 32'h0);
  endtask : sc_reset

  task automatic sc_trig();
    wr(ADDR_CTL, 32'h057);
    wr(ADDR_REG0, 32'h1234);
    pin(1'b1, 1'b0);
    rchk(ADDR_COUNT, 32'h1234);
    pin(1'b0, 1'b0);
    wr(ADDR_CTL, 32'h457);
    wr(ADDR_COUNT, 32'h0abc);
    pin(1'b1, 1'b0);
    rchk(ADDR_REG0, 32'h0abc);
    pin(1'b1, 1'b1);
    rchk(ADDR_REG1, 32'h0abc);
    pin(1'b0, 1'b0);
    wr(ADDR_CTL, 32'h657);
    wr(ADDR_COUNT, 32'h0555);
    pin(1'b0, 1'b1);
    rchk(ADDR_REG1, 32'h0abc);
    pin(1'b0, 1'b0);
    rchk(ADDR_FLAGS, 32'h0c);
  endtask : sc_trig

  task automatic sc_updn();
    wr(ADDR_CTL, 32'h858);
    wr(ADDR_COUNT, 32'h0010);
    pin(1'b1, 1'b0);
    rchk(ADDR_COUNT, 32'h0011);
    pin(1'b0, 1'b1);
    rchk(ADDR_COUNT, 32'h0010);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b1);
    rchk(ADDR_COUNT, 32'h000f);
    pin(1'b0, 1'b0);
  endtask : sc_updn

  task automatic sc_autod();
    wr(ADDR_CTL, 32'h90c);
    wr(ADDR_COUNT, 32'h0010);
    pin(1'b0, 1'b1);
    rchk(ADDR_COUNT, 32'h0011);
    pin(1'b0, 1'b0);
    rchk(ADDR_COUNT, 32'h0010);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
    rchk(ADDR_COUNT, 32'h0010);
    pin(1'b1, 1'b0);
    rchk(ADDR_COUNT, 32'h0010);
    pin(1'b0, 1'b0);
  endtask : sc_autod

  // two count reads in a row: 0 falling, 1 rising, 2 holding
  task automatic dir_chk(input logic [1:0] how);
    logic [31:0] q0;
    logic [31:0] q1;
    bus(ADDR_COUNT, 1'b0, 32'h0, q0);
    bus(ADDR_COUNT, 1'b0, 32'h0, q1);
    chk({31'h0, (how == 2'h2) ? (q1 == q0) : (how[0] ? (q1 > q0) : (q1 < q0))}, 32'h1);
  endtask : dir_chk

  // direction, gate and external clock pin functions
  task automatic sc_dir();
    wr(ADDR_CTL, 32'h849);
    wr(ADDR_COUNT, 32'h0010);
    pin(1'b1, 1'b1);
    rchk(ADDR_COUNT, 32'h0011);
    pin(1'b0, 1'b0);
    pin(1'b0, 1'b1);
    rchk(ADDR_COUNT, 32'h0010);
    pin(1'b0, 1'b0);
    wr(ADDR_CTL, 32'h80b);
    wr(ADDR_COUNT, 32'h8000);
    pin(1'b1, 1'b0);
    dir_chk(2'h1);
    pin(1'b0, 1'b0);
    dir_chk(2'h0);
    wr(ADDR_CTL, 32'h95a);
    pin(1'b0, 1'b1);
    dir_chk(2'h0);
    pin(1'b1, 1'b0);
    dir_chk(2'h1);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b1);
    dir_chk(2'h0);
    pin(1'b0, 1'b0);
    wr(ADDR_CTL, 32'h91f);
    dir_chk(2'h1);
    pin(1'b0, 1'b1);
    dir_chk(2'h2);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b1);
    rchk(ADDR_COUNT, 32'h0abc);
    pin(1'b0, 1'b0);
    wr(ADDR_CTL, 32'h95d);
    wr(ADDR_COUNT, 32'h0020);
    pin(1'b0, 1'b1);
    rchk(ADDR_COUNT, 32'h0021);
    pin(1'b1, 1'b0);
    rchk(ADDR_COUNT, 32'h0abc);
    pin(1'b0, 1'b0);
    wr(ADDR_CTL, 32'h95e);
    wr(ADDR_COUNT, 32'h0030);
    pin(1'b1, 1'b0);
    rchk(ADDR_COUNT, 32'h0031);
    pin(1'b0, 1'b1);
    rchk(ADDR_REG1, 32'h0031);
    pin(1'b0, 1'b0);
  endtask : sc_dir

  task automatic sc_out_irq();
    // clear flags left pending by earlier scenarios
    wr(ADDR_FLAGS, 32'h7f);
    wr(ADDR_CTL, 32'h858);
    wr(ADDR_CMP1, 32'h7777);
    wr(ADDR_COUNT, 32'h0010);
    wr(ADDR_CMP0, 32'h0011);
    wr(ADDR_OA_CTL, 32'hb1);
    wr(ADDR_OB_CTL, 32'h40);
    repeat (2) @(posedge hclk);
    chk({out_a, out_b}, 32'h1);
    wr(ADDR_VEC, 32'ha8);
    wr(ADDR_MASK, 32'h91);
    pin(1'b1, 1'b0);
    chk({out_a, out_b}, 32'h3);
    chk({irq_req, taken_vec}, 32'h1ae);
    pin(1'b0, 1'b0);
    wr(ADDR_COUNT, 32'h0010);
    pin(1'b1, 1'b0);
    rchk(ADDR_FLAGS, 32'h21);
    pin(1'b0, 1'b0);
    e0 = ev_cnt;
    wr(ADDR_COUNT, 32'h0);
    pin(1'b0, 1'b1);
    rchk(ADDR_FLAGS, 32'h31);
    chk(taken_vec, 32'ha8);
    chk(ev_cnt - e0, 32'h1);
    chk({out_a, out_b}, 32'h1);
    wr(ADDR_MASK, 32'h11);
    repeat (3) @(posedge hclk);
    chk(irq_req, 32'h0);
    wr(ADDR_FLAGS, 32'h7f);
    rchk(ADDR_FLAGS, 32'h0);
    pin(1'b0, 1'b0);
  endtask : sc_out_irq

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    sc_reset();
    sc_trig();
    sc_updn();
    sc_autod();
    sc_dir();
    sc_out_irq();
    close_out();
  end
endmodule : mft_pins_irq_tb
